//--- core/clr_limit_regs.sv
// Charger limit register bank: system voltage floor, host input current limit and controls.
//
// Notes on behaviour
// - Voltage floor spans 1.024 V to 16.128 V in 256 mV steps, binary weighted.
// - Floor writes below 1.024 V or above 16.128 V are dropped unchanged.
// - Floor default at reset follows cell strap: 3.584, 6.144, 9.216, 12.288 V.
// - Floor field sits in bits 13..8, weights 8192 down to 256 mV.
// - Floor write with bit 15 or 14 set is invalid and dropped.
// - Input overcurrent or undervoltage throttles charge current toward zero.
// - Host input limit spans 50 mA to 6400 mA in 50 mA steps.
// - Host input limit defaults to 3.3 A and reloads on adapter removal.
// - Input limit has fixed 50 mA offset; code zero means 50 mA.
// - Programmed input limit is a maximum, not a typical current.
// - Input-limit pin ignored if disabled by 0x31 bit 7 or above 4.0 V.
// - Input limit register: field bits 14..8, reserved bit 15, read-only low byte.
// - Input limit weights 3200 down to 50 mA from bit 14 to bit 8.
// - Linear battery mode is bit 2 of register 0x12, enabled after reset.
module clr_limit_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] cellCountStrap,
    input wire logic adapterPresent,
    input wire logic inputLimitPinGrounded,
    input wire logic inputLimitPinAboveOff,
    input wire logic inputOverCurrent,
    input wire logic inputUnderVoltage,
    output logic [13:0] floorMv,
    output logic [12:0] inputLimitMa,
    output logic linearBatteryMode,
    output logic autoWake,
    output logic inputOffState,
    output logic externalLoopActive,
    output logic chargeThrottle
);
    clr_reg_if bus ();

    logic [5:0] floor_r, floor_nxt;
    logic [6:0] hostIin_r, hostIin_nxt;
    logic linear_r, linear_nxt;
    logic wake_r, wake_nxt;
    logic pinDis_r, pinDis_nxt;
    logic adapterPrev_r;
    logic [13:0] floorMv_r, floorMv_nxt;
    logic [12:0] limitMa_r, limitMa_nxt;
    logic inputOff_r, inputOff_nxt;
    logic extLoop_r, extLoop_nxt;
    logic throttle_r, throttle_nxt;
    logic sdaOut_r;
    logic [5:0] floorDefault;
    logic [5:0] wrFloor;
    logic pinHonoured;
    logic [15:0] rdWord;

    clr_smbus_slave u_target (
        .clk(clk),
        .rst_n(rst_n),
        .scl(scl),
        .sdaIn(sdaIn),
        .sdaOe(sdaOe),
        .regs(bus.target)
    );

    always_comb
    begin
        case (cellCountStrap)
            2'h0: floorDefault = clr_pkg::FLOOR_DEF_1S;
            2'h1: floorDefault = clr_pkg::FLOOR_DEF_2S;
            2'h2: floorDefault = clr_pkg::FLOOR_DEF_3S;
            default: floorDefault = clr_pkg::FLOOR_DEF_4S;
        endcase
    end

    // The low byte of a floor or input limit write is never looked at.
    assign wrFloor = bus.wrData[clr_pkg::FLOOR_MSB:clr_pkg::FLOOR_LSB];

    always_comb
    begin
        floor_nxt = floor_r;
        hostIin_nxt = hostIin_r;
        linear_nxt = linear_r;
        wake_nxt = wake_r;
        pinDis_nxt = pinDis_r;
        if (bus.wrStrobe)
        begin
            case (bus.cmd)
                clr_pkg::OFS_SYS_FLOOR:
                    if (bus.wrData[15:clr_pkg::FLOOR_RSV_LSB] == 2'h0
                        && wrFloor >= clr_pkg::FLOOR_MIN_CODE
                        && wrFloor <= clr_pkg::FLOOR_MAX_CODE)
                        floor_nxt = wrFloor;
                clr_pkg::OFS_HOST_IIN:
                    if (!bus.wrData[clr_pkg::IIN_RSV_BIT])
                        hostIin_nxt = bus.wrData[clr_pkg::IIN_MSB:clr_pkg::IIN_LSB];
                clr_pkg::OFS_LINEAR_CTRL:
                    linear_nxt = bus.wrData[clr_pkg::LINEAR_BIT];
                clr_pkg::OFS_WAKE_CTRL:
                    wake_nxt = bus.wrData[clr_pkg::WAKE_BIT];
                clr_pkg::OFS_PIN_CTRL:
                    pinDis_nxt = bus.wrData[clr_pkg::PIN_DIS_BIT];
                default:
                    floor_nxt = floor_r;
            endcase
        end
        // Removal of the adapter outranks a host write in the same cycle, so a stale
        // high limit can never survive into the next attach.
        if (adapterPrev_r && !adapterPresent)
            hostIin_nxt = clr_pkg::HOST_IIN_RESET[clr_pkg::IIN_MSB:clr_pkg::IIN_LSB];
    end

    always_comb
    begin
        rdWord = 16'h0000;
        case (bus.cmd)
            clr_pkg::OFS_SYS_FLOOR:
                rdWord[clr_pkg::FLOOR_MSB:clr_pkg::FLOOR_LSB] = floor_r;
            clr_pkg::OFS_HOST_IIN:
                rdWord[clr_pkg::IIN_MSB:clr_pkg::IIN_LSB] = hostIin_r;
            clr_pkg::OFS_LINEAR_CTRL:
                rdWord[clr_pkg::LINEAR_BIT] = linear_r;
            clr_pkg::OFS_WAKE_CTRL:
                rdWord[clr_pkg::WAKE_BIT] = wake_r;
            clr_pkg::OFS_PIN_CTRL:
                rdWord[clr_pkg::PIN_DIS_BIT] = pinDis_r;
            default:
                rdWord = 16'h0000;
        endcase
    end
    assign bus.rdData = rdWord;

    assign pinHonoured = !pinDis_r && !inputLimitPinAboveOff;

    always_comb
    begin
        floorMv_nxt = {floor_r, 8'h00};
        // Each code is a ceiling: code n allows at most (n + 1) x 50 mA.
        limitMa_nxt = 13'((13'(hostIin_r) + 13'h0001)
            * clr_pkg::IIN_STEP_MA);
        inputOff_nxt = pinHonoured && inputLimitPinGrounded;
        extLoop_nxt = pinHonoured && !inputLimitPinGrounded;
        throttle_nxt = inputOverCurrent || inputUnderVoltage;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            floor_r <= floorDefault;
            hostIin_r <= clr_pkg::HOST_IIN_RESET[clr_pkg::IIN_MSB:clr_pkg::IIN_LSB];
            linear_r <= clr_pkg::LINEAR_RESET;
            wake_r <= clr_pkg::WAKE_RESET;
            pinDis_r <= clr_pkg::PIN_DIS_RESET;
            adapterPrev_r <= 1'b0;
            floorMv_r <= 14'h0000;
            limitMa_r <= 13'h0000;
            inputOff_r <= 1'b0;
            extLoop_r <= 1'b0;
            throttle_r <= 1'b0;
            sdaOut_r <= 1'b0;
        end
        else
        begin
            floor_r <= floor_nxt;
            hostIin_r <= hostIin_nxt;
            linear_r <= linear_nxt;
            wake_r <= wake_nxt;
            pinDis_r <= pinDis_nxt;
            adapterPrev_r <= adapterPresent;
            floorMv_r <= floorMv_nxt;
            limitMa_r <= limitMa_nxt;
            inputOff_r <= inputOff_nxt;
            extLoop_r <= extLoop_nxt;
            throttle_r <= throttle_nxt;
            sdaOut_r <= 1'b0;
        end
    end

    assign sdaOut = sdaOut_r;
    assign floorMv = floorMv_r;
    assign inputLimitMa = limitMa_r;
    assign linearBatteryMode = linear_r;
    assign autoWake = wake_r;
    assign inputOffState = inputOff_r;
    assign externalLoopActive = extLoop_r;
    assign chargeThrottle = throttle_r;
endmodule // clr_limit_regs

//--- core/clr_pkg.sv
// Package with register map, field layout and reset values of the limit registers, and bus target states.
package clr_pkg;
    // Bus target address; the value is arbitrary.
    localparam logic [6:0] BUS_ADDR = 7'h09;
    localparam logic [7:0] OFS_LINEAR_CTRL = 8'h12;
    localparam logic [7:0] OFS_WAKE_CTRL = 8'h30;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h31;
    localparam logic [7:0] OFS_SYS_FLOOR = 8'h3E;
    localparam logic [7:0] OFS_HOST_IIN = 8'h3F;
    localparam int LINEAR_BIT = 2;
    localparam int WAKE_BIT = 0;
    localparam int PIN_DIS_BIT = 7;
    localparam int FLOOR_LSB = 8;
    localparam int FLOOR_MSB = 13;
    localparam int FLOOR_RSV_LSB = 14;
    localparam int IIN_LSB = 8;
    localparam int IIN_MSB = 14;
    localparam int IIN_RSV_BIT = 15;
    localparam logic [5:0] FLOOR_MIN_CODE = 6'h04;
    localparam logic [5:0] FLOOR_MAX_CODE = 6'h3F;
    localparam logic [5:0] FLOOR_DEF_1S = 6'h0E;
    localparam logic [5:0] FLOOR_DEF_2S = 6'h18;
    localparam logic [5:0] FLOOR_DEF_3S = 6'h24;
    localparam logic [5:0] FLOOR_DEF_4S = 6'h30;
    localparam logic [15:0] HOST_IIN_RESET = 16'h4100;
    localparam logic [12:0] IIN_STEP_MA = 13'h0032;
    localparam logic LINEAR_RESET = 1'b1;
    localparam logic WAKE_RESET = 1'b1;
    localparam logic PIN_DIS_RESET = 1'b0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RXDONE = 3'b010,
        ST_ACKTX = 3'b011,
        ST_TX = 3'b100,
        ST_ACKRX = 3'b101,
        ST_TXNEXT = 3'b110
    } clr_state_t;
    typedef enum logic [2:0] {
        PH_ADDR = 3'b000,
        PH_CMD = 3'b001,
        PH_LO = 3'b010,
        PH_HI = 3'b011,
        PH_OVER = 3'b100
    } clr_phase_t;
endpackage

//--- core/clr_reg_if.sv
// Interface carrying register accesses from the bus target to the register bank.
interface clr_reg_if;
    logic [7:0] cmd;
    logic [15:0] wrData;
    logic wrStrobe;
    logic [15:0] rdData;
    modport target (output cmd, output wrData, output wrStrobe, input rdData);
    modport bank (input cmd, input wrData, input wrStrobe, output rdData);
endinterface

//--- core/clr_smbus_slave.sv
// Two-wire bus target handling write-word and read-word transfers.
module clr_smbus_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOe,
    clr_reg_if.target regs
);
    clr_pkg::clr_state_t state_r, state_nxt;
    clr_pkg::clr_phase_t phase_r, phase_nxt;
    logic [2:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] dataLo_r, dataLo_nxt;
    logic [15:0] txShift_r, txShift_nxt;
    logic [15:0] wrData_r, wrData_nxt;
    logic isRead_r, isRead_nxt;
    logic sdaOe_r, sdaOe_nxt;
    logic wrStrobe_r, wrStrobe_nxt;
    logic sclPrev_r, sdaPrev_r;
    logic sclRise, sclFall, startCond, stopCond;

    assign sclRise = scl && !sclPrev_r;
    assign sclFall = !scl && sclPrev_r;
    assign startCond = scl && sclPrev_r && sdaPrev_r && !sdaIn;
    assign stopCond = scl && sclPrev_r && !sdaPrev_r && sdaIn;

    always_comb
    begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        bitCnt_nxt = bitCnt_r;
        shift_nxt = shift_r;
        cmd_nxt = cmd_r;
        dataLo_nxt = dataLo_r;
        txShift_nxt = txShift_r;
        wrData_nxt = wrData_r;
        isRead_nxt = isRead_r;
        sdaOe_nxt = sdaOe_r;
        wrStrobe_nxt = 1'b0;
        if (startCond)
        begin
            state_nxt = clr_pkg::ST_RX;
            phase_nxt = clr_pkg::PH_ADDR;
            bitCnt_nxt = 3'h0;
            sdaOe_nxt = 1'b0;
        end
        else if (stopCond)
        begin
            state_nxt = clr_pkg::ST_IDLE;
            sdaOe_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                clr_pkg::ST_RX:
                    if (sclRise)
                    begin
                        shift_nxt = {shift_r[6:0], sdaIn};
                        bitCnt_nxt = bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                            state_nxt = clr_pkg::ST_RXDONE;
                    end
                clr_pkg::ST_RXDONE:
                    if (sclFall)
                    begin
                        state_nxt = clr_pkg::ST_ACKTX;
                        sdaOe_nxt = 1'b1;
                        case (phase_r)
                            clr_pkg::PH_ADDR:
                                if (shift_r[7:1] != clr_pkg::BUS_ADDR)
                                begin
                                    state_nxt = clr_pkg::ST_IDLE;
                                    sdaOe_nxt = 1'b0;
                                end
                                else
                                begin
                                    isRead_nxt = shift_r[0];
                                    phase_nxt = clr_pkg::PH_CMD;
                                    // Low byte goes first on the wire.
                                    txShift_nxt = {regs.rdData[7:0], regs.rdData[15:8]};
                                end
                            clr_pkg::PH_CMD:
                            begin
                                cmd_nxt = shift_r;
                                phase_nxt = clr_pkg::PH_LO;
                            end
                            clr_pkg::PH_LO:
                            begin
                                dataLo_nxt = shift_r;
                                phase_nxt = clr_pkg::PH_HI;
                            end
                            clr_pkg::PH_HI:
                            begin
                                wrData_nxt = {shift_r, dataLo_r};
                                wrStrobe_nxt = 1'b1;
                                phase_nxt = clr_pkg::PH_OVER;
                            end
                            default:
                            begin
                                state_nxt = clr_pkg::ST_IDLE;
                                sdaOe_nxt = 1'b0;
                            end
                        endcase
                    end
                clr_pkg::ST_ACKTX:
                    if (sclFall)
                    begin
                        bitCnt_nxt = 3'h0;
                        if (isRead_r)
                        begin
                            state_nxt = clr_pkg::ST_TX;
                            sdaOe_nxt = !txShift_r[15];
                        end
                        else
                        begin
                            state_nxt = clr_pkg::ST_RX;
                            sdaOe_nxt = 1'b0;
                        end
                    end
                clr_pkg::ST_TX:
                    if (sclFall)
                    begin
                        txShift_nxt = {txShift_r[14:0], 1'b0};
                        bitCnt_nxt = bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7)
                        begin
                            state_nxt = clr_pkg::ST_ACKRX;
                            sdaOe_nxt = 1'b0;
                        end
                        else
                            sdaOe_nxt = !txShift_r[14];
                    end
                clr_pkg::ST_ACKRX:
                    if (sclRise)
                        state_nxt = sdaIn ? clr_pkg::ST_IDLE : clr_pkg::ST_TXNEXT;
                clr_pkg::ST_TXNEXT:
                    if (sclFall)
                    begin
                        state_nxt = clr_pkg::ST_TX;
                        bitCnt_nxt = 3'h0;
                        sdaOe_nxt = !txShift_r[15];
                    end
                default:
                    state_nxt = clr_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= clr_pkg::ST_IDLE;
            phase_r <= clr_pkg::PH_ADDR;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            dataLo_r <= 8'h00;
            txShift_r <= 16'h0000;
            wrData_r <= 16'h0000;
            isRead_r <= 1'b0;
            sdaOe_r <= 1'b0;
            wrStrobe_r <= 1'b0;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bitCnt_r <= bitCnt_nxt;
            shift_r <= shift_nxt;
            cmd_r <= cmd_nxt;
            dataLo_r <= dataLo_nxt;
            txShift_r <= txShift_nxt;
            wrData_r <= wrData_nxt;
            isRead_r <= isRead_nxt;
            sdaOe_r <= sdaOe_nxt;
            wrStrobe_r <= wrStrobe_nxt;
            sclPrev_r <= scl;
            sdaPrev_r <= sdaIn;
        end
    end

    assign sdaOe = sdaOe_r;
    assign regs.cmd = cmd_r;
    assign regs.wrData = wrData_r;
    assign regs.wrStrobe = wrStrobe_r;
endmodule // clr_smbus_slave

//--- sim/clr_host_model.sv
// Behavioural bus master standing in for the host controller.
module clr_host_model (
    input wire logic clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;
    // SCL high time in clocks, a third of the bit time; the model needs at least two, larger values model a slow host.
    int halfClk = 4;
    initial
    begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic xbit(input logic b, output logic s);
        sdaPull <= ~b;
        hold(halfClk);
        scl <= 1'b1;
        hold(halfClk - 2);
        #1 s = sdaLine;
        hold(2);
        scl <= 1'b0;
        hold(halfClk);
    endtask
    task automatic startCond();
        sdaPull <= 1'b0;
        hold(halfClk);
        scl <= 1'b1;
        hold(halfClk);
        sdaPull <= 1'b1;
        hold(halfClk);
        scl <= 1'b0;
        hold(halfClk);
    endtask
    task automatic stopCond();
        sdaPull <= 1'b1;
        hold(halfClk);
        scl <= 1'b1;
        hold(halfClk);
        sdaPull <= 1'b0;
        hold(halfClk);
    endtask
    task automatic xbyte(input logic [7:0] o, input logic ackOut, output logic [7:0] i,
                         output logic ackIn);
        for (int k = 7; k >= 0; k--)
            xbit(o[k], i[k]);
        xbit(ackOut, ackIn);
    endtask
    task automatic wr(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] d,
                      output logic ok);
        logic [7:0] junk;
        logic a0, a1, a2, a3;
        startCond();
        xbyte({addr, 1'b0}, 1'b1, junk, a0);
        xbyte(cmd, 1'b1, junk, a1);
        xbyte(d[7:0], 1'b1, junk, a2);
        xbyte(d[15:8], 1'b1, junk, a3);
        stopCond();
        ok = ~(a0 | a1 | a2 | a3);
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic [7:0] junk;
        logic a0, a1, a2, n0, n1;
        startCond();
        xbyte({clr_pkg::BUS_ADDR, 1'b0}, 1'b1, junk, a0);
        xbyte(cmd, 1'b1, junk, a1);
        startCond();
        xbyte({clr_pkg::BUS_ADDR, 1'b1}, 1'b1, junk, a2);
        xbyte(8'hFF, 1'b0, d[7:0], n0);
        xbyte(8'hFF, 1'b1, d[15:8], n1);
        stopCond();
        ok = ~(a0 | a1 | a2);
    endtask
endmodule // clr_host_model

//--- sim/clr_limit_regs_props.sv
// Concurrent checks on the ports of the limit register bank.
module clr_limit_regs_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [1:0] cellCountStrap,
    input wire logic adapterPresent,
    input wire logic inputLimitPinGrounded,
    input wire logic inputLimitPinAboveOff,
    input wire logic inputOverCurrent,
    input wire logic inputUnderVoltage,
    input wire logic [13:0] floorMv,
    input wire logic [12:0] inputLimitMa,
    input wire logic linearBatteryMode,
    input wire logic autoWake,
    input wire logic inputOffState,
    input wire logic externalLoopActive,
    input wire logic chargeThrottle
);
    logic [2:0] relCnt_r;
    logic [2:0] relCnt_nxt;
    logic [1:0] strap_r;
    logic [1:0] strap_nxt;
    logic [13:0] dfltMv;
    // Outputs lag reset release by up to two clocks, so checks wait on this count.
    always_comb
    begin
        relCnt_nxt = (relCnt_r == 3'h7) ? relCnt_r : relCnt_r + 3'h1;
        strap_nxt = strap_r;
        if (!rst_n)
        begin
            relCnt_nxt = 3'h0;
            strap_nxt = cellCountStrap;
        end
        case (strap_r)
            2'h0: dfltMv = 14'h0E00;
            2'h1: dfltMv = 14'h1800;
            2'h2: dfltMv = 14'h2400;
            default: dfltMv = 14'h3000;
        endcase
    end
    always_ff @(posedge clk)
    begin
        relCnt_r <= relCnt_nxt;
        strap_r <= strap_nxt;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence settled;
        relCnt_r == 3'h3;
    endsequence
    sequence adapterDrop;
        $fell(adapterPresent);
    endsequence
    sequence demand;
        relCnt_r >= 3'h2 && (inputOverCurrent || inputUnderVoltage);
    endsequence
    sequence noDemand;
        relCnt_r >= 3'h2 && !inputOverCurrent && !inputUnderVoltage;
    endsequence
    AST_FLOOR_STEP: assert property (floorMv[7:0] == 8'h00)
        else $error("floor not on a 256 mV step");
    AST_FLOOR_RANGE:
        assert property (relCnt_r >= 3'h3 |-> floorMv >= 14'h0400)
        else $error("floor below 1024 mV");
    AST_FLOOR_DEFAULT: assert property (settled |-> floorMv == dfltMv)
        else $error("floor default wrong for strap");
    AST_IIN_DEFAULT: assert property (settled |-> inputLimitMa == 13'h0CE4)
        else $error("input limit default not 3300 mA");
    AST_IIN_RELOAD:
        assert property (adapterDrop |-> ##[1:3] inputLimitMa == 13'h0CE4)
        else $error("input limit not reloaded on adapter removal");
    AST_IIN_GRID:
        assert property (relCnt_r >= 3'h3 |-> inputLimitMa >= 13'h0032
            && inputLimitMa <= 13'h1900 && inputLimitMa % 13'h0032 == 13'h0000)
        else $error("input limit off the 50 mA grid");
    AST_THROTTLE_ON: assert property (demand [*2] |-> chargeThrottle)
        else $error("throttle missing under input overload");
    AST_THROTTLE_OFF: assert property (noDemand [*2] |-> !chargeThrottle)
        else $error("throttle without input overload");
    AST_PIN_IGNORED:
        assert property ((relCnt_r >= 3'h2 && inputLimitPinAboveOff) [*3]
            |-> !inputOffState && !externalLoopActive)
        else $error("pin honoured while above off level");
    AST_LINEAR_DEFAULT:
        assert property (relCnt_r == 3'h1 |-> linearBatteryMode && autoWake)
        else $error("linear mode not on after reset");
endmodule // clr_limit_regs_props

//--- sim/tb.sv
// Self-checking bench for the limit register bank.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, scl, hostPull, sdaOe, sdaOut, sdaLine, ok;
    logic adapterPresent, pinGnd, pinHigh, overCur, underVolt;
    logic linearBatteryMode, autoWake, inputOffState, externalLoopActive, chargeThrottle;
    logic [1:0] strap;
    logic [13:0] floorMv;
    logic [12:0] inputLimitMa;
    logic [15:0] rdVal;
    int n_errors = 0;
    int n_tests = 0;
    logic [15:0] flWr [6] = '{16'h0400, 16'h0300, 16'h3F00, 16'h4A00, 16'h8500, 16'h0AFF};
    logic [15:0] flRd [6] = '{16'h0400, 16'h0400, 16'h3F00, 16'h3F00, 16'h3F00, 16'h0A00};
    logic [15:0] inWr [4] = '{16'h0000, 16'h7F00, 16'h8200, 16'h01AB};
    logic [15:0] inRd [4] = '{16'h0000, 16'h7F00, 16'h7F00, 16'h0100};
    logic [13:0] dflt [4] = '{14'h0E00, 14'h1800, 14'h2400, 14'h3000};
    // Open drain with a pull-up: the line is high unless some party pulls it.
    assign sdaLine = ~(hostPull | sdaOe);
    clr_limit_regs uut (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .cellCountStrap(strap),
        .adapterPresent(adapterPresent), .inputLimitPinGrounded(pinGnd),
        .inputLimitPinAboveOff(pinHigh), .inputOverCurrent(overCur),
        .inputUnderVoltage(underVolt), .floorMv(floorMv), .inputLimitMa(inputLimitMa),
        .linearBatteryMode(linearBatteryMode), .autoWake(autoWake),
        .inputOffState(inputOffState), .externalLoopActive(externalLoopActive),
        .chargeThrottle(chargeThrottle));
    clr_host_model host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaPull(hostPull));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrChk(input logic [7:0] cmd, input logic [15:0] d);
        host.wr(clr_pkg::BUS_ADDR, cmd, d, ok);
        chk("write ack", 16'h0001, 16'(ok));
    endtask
    task automatic rdChk(input logic [7:0] cmd, input logic [15:0] exp, input string what);
        host.rd(cmd, rdVal, ok);
        chk("read ack", 16'h0001, 16'(ok));
        chk(what, exp, rdVal);
    endtask
    task automatic rstDut(input logic [1:0] s);
        strap <= s;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    initial
    begin
        {rst_n, strap, pinGnd, pinHigh, overCur, underVolt} = '0;
        adapterPresent = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            rstDut(2'(s));
            chk("floorMv default", {2'b00, dflt[s]}, {2'b00, floorMv});
        end
        rdChk(clr_pkg::OFS_SYS_FLOOR, 16'h3000, "floor reset");
        rdChk(clr_pkg::OFS_HOST_IIN, 16'h4100, "iin reset");
        $display("test reset defaults done");
        for (int i = 0; i < 6; i++)
        begin
            wrChk(clr_pkg::OFS_SYS_FLOOR, flWr[i]);
            rdChk(clr_pkg::OFS_SYS_FLOOR, flRd[i], "floor reg");
            chk("floorMv", flRd[i], {2'b00, floorMv});
        end
        $display("test floor range done");
        for (int k = 0; k < 7; k++)
        begin
            wrChk(clr_pkg::OFS_HOST_IIN, 16'h0100 << k);
            chk("iin weight", 16'h0032 * ((16'h0001 << k) + 16'h0001),
                16'(inputLimitMa));
        end
        for (int i = 0; i < 4; i++)
        begin
            wrChk(clr_pkg::OFS_HOST_IIN, inWr[i]);
            rdChk(clr_pkg::OFS_HOST_IIN, inRd[i], "iin reg");
            chk("iin mA", ({9'h000, inRd[i][14:8]} + 16'h0001) * 16'h0032,
                16'(inputLimitMa));
        end
        adapterPresent <= 1'b0;
        settle();
        chk("iin reload", 16'h0CE4, 16'(inputLimitMa));
        host.halfClk = 9;
        rdChk(clr_pkg::OFS_HOST_IIN, 16'h4100, "iin reload reg");
        host.halfClk = 4;
        $display("test input limit done");
        pinGnd <= 1'b1;
        settle();
        chk("input off", 16'h0001, 16'(inputOffState));
        adapterPresent <= 1'b1;
        wrChk(clr_pkg::OFS_LINEAR_CTRL, 16'h0000);
        chk("linear mode", 16'h0000, 16'(linearBatteryMode));
        wrChk(clr_pkg::OFS_WAKE_CTRL, 16'h0000);
        chk("auto wake", 16'h0000, 16'(autoWake));
        rdChk(clr_pkg::OFS_SYS_FLOOR, 16'h0A00, "floor kept");
        wrChk(clr_pkg::OFS_HOST_IIN, 16'h0500);
        chk("low limit", 16'h012C, 16'(inputLimitMa));
        pinGnd <= 1'b0;
        settle();
        chk("ext loop", 16'h0001, 16'({inputOffState, externalLoopActive}));
        wrChk(clr_pkg::OFS_PIN_CTRL, 16'h0080);
        pinGnd <= 1'b1;
        settle();
        chk("pin disabled", 16'h0000, 16'({inputOffState, externalLoopActive}));
        wrChk(clr_pkg::OFS_PIN_CTRL, 16'h0000);
        chk("pin enabled", 16'h0002, 16'({inputOffState, externalLoopActive}));
        {pinGnd, pinHigh} <= 2'b01;
        settle();
        chk("pin high", 16'h0000, 16'({inputOffState, externalLoopActive}));
        pinHigh <= 1'b0;
        $display("test no switch sequence done");
        for (int c = 0; c < 4; c++)
        begin
            {overCur, underVolt} <= 2'(c);
            settle();
            chk("throttle", 16'(c != 0), 16'(chargeThrottle));
        end
        host.wr(7'h0A, clr_pkg::OFS_SYS_FLOOR, 16'h2000, ok);
        chk("foreign nack and drive", 16'h0000, 16'({ok, sdaOut}));
        rdChk(clr_pkg::OFS_SYS_FLOOR, 16'h0A00, "floor untouched");
        rdChk(8'h20, 16'h0000, "unmapped");
        $display("test throttle and refusals done");
        end_sim();
    end
endmodule // tb
bind clr_limit_regs clr_limit_regs_props props (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .cellCountStrap(cellCountStrap),
    .adapterPresent(adapterPresent), .inputLimitPinGrounded(inputLimitPinGrounded),
    .inputLimitPinAboveOff(inputLimitPinAboveOff), .inputOverCurrent(inputOverCurrent),
    .inputUnderVoltage(inputUnderVoltage), .floorMv(floorMv), .inputLimitMa(inputLimitMa),
    .linearBatteryMode(linearBatteryMode), .autoWake(autoWake),
    .inputOffState(inputOffState), .externalLoopActive(externalLoopActive),
    .chargeThrottle(chargeThrottle));
